// file: dv/cca_counter_array_sva.sv
`timescale 1ns/1ps
module cca_chk
    import cca_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   sys_rst,
    input wire cca_bus_s               reg_req,
    input wire logic [7:0]             reg_rdata_q,
    input wire logic                   timer0_overflow,
    input wire logic                   external_count_input,
    input wire logic                   cpu_idle,
    input wire logic [NUM_MODULES-1:0] module_pin_in,
    input wire logic [NUM_MODULES-1:0] module_pin_out,
    input wire logic [NUM_MODULES-1:0] module_pin_oe,
    input wire logic                   irq_q,
    input wire logic                   watchdog_reset_q
);
    logic [7:0] mm_q [5];
    logic [7:0] cm_q;
    logic       run_q;
    logic [4:0] pin_q;
    logic [4:0] oe_w;
    logic [4:0] cap_w;
    logic [4:0] ie_w;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Shadow copies of the software-written mode and control bits.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mm_q <= '{default: 8'h00};
            cm_q <= 8'h00;
            run_q <= 1'b0;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_MODE) cm_q <= reg_req.wdata;
            if (reg_req.addr == ADDR_CONTROL) run_q <= reg_req.wdata[6];
            for (int n = 0; n < 5; n++) begin
                if (reg_req.addr == ADDR_MODMODE0 + 8'(n)) mm_q[n] <= reg_req.wdata;
            end
        end
    end
    always_ff @(posedge clock) begin
        pin_q <= module_pin_in;
    end
    always_comb begin
        for (int n = 0; n < 5; n++) begin
            oe_w[n] = mm_q[n][1] | mm_q[n][2];
            cap_w[n] = mm_q[n][5] & mm_q[n][0] & module_pin_in[n] & ~pin_q[n];
            ie_w[n] = mm_q[n][0];
        end
    end
    property p_rd_idle;
        !reg_req.rd |=> reg_rdata_q == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its slot");
    property p_run_rb;
        reg_req.rd && reg_req.addr == ADDR_CONTROL |=> reg_rdata_q[6] == run_q;
    endproperty
    a_run_rb: assert property (p_run_rb)
        else $error("run bit readback wrong");
    property p_mode_rb;
        reg_req.rd && reg_req.addr == ADDR_MODMODE0 |=> reg_rdata_q == {1'b0, mm_q[0][6:0]};
    endproperty
    a_mode_rb: assert property (p_mode_rb)
        else $error("module mode readback wrong");
    property p_oe;
        module_pin_oe == $past(oe_w);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin drive enable wrong");
    property p_cap_irq;
        |cap_w |-> ##[1:4] irq_q;
    endproperty
    a_cap_irq: assert property (p_cap_irq)
        else $error("capture gave no interrupt");
    property p_irq_off;
        (ie_w == 5'h00 && !cm_q[0])[*2] |-> !irq_q;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with all enables off");
    property p_wd_en;
        watchdog_reset_q |-> $past(cm_q[6]);
    endproperty
    a_wd_en: assert property (p_wd_en)
        else $error("reset request without watchdog enable");
    property p_wd_pulse;
        watchdog_reset_q |=> !watchdog_reset_q;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("reset request longer than one cycle");
    c_cap: cover property (|cap_w ##[1:4] irq_q);
    c_wd: cover property (watchdog_reset_q);
    c_pwm: cover property (module_pin_oe[3] && module_pin_out[3]);
endmodule

bind cca_counter_array cca_chk cca_chk_i (.*);

// file: dv/cca_pins.sv
`timescale 1ns/1ps
module cca_pins (
    input  wire logic       clock,
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    input  wire logic [4:0] drive,
    input  wire logic       ext_en,
    output logic [4:0]      pin_lvl,
    output logic            ext_cnt
);
    logic ph = 1'b0;
    // Pin n is driven by module n when enabled, else by the outside level.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drive);
    initial ext_cnt = 1'b0;
    // The count input toggles every second clock, a quarter of the clock rate.
    always @(posedge clock) begin
        if (ext_en) begin
            ph <= ~ph;
            if (ph) ext_cnt <= ~ext_cnt;
        end
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import cca_pkg::*;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    cca_bus_s   req = '0;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic       t0 = 1'b0;
    logic       idle = 1'b0;
    logic       ext_en = 1'b0;
    logic       ext;
    logic       irq;
    logic       wdr;
    logic       wd_seen = 1'b0;
    logic [4:0] drv = 5'h04;
    logic [4:0] pin_lvl;
    logic [4:0] pout;
    logic [4:0] poe;
    int         err_total = 0;
    int         tests_run = 0;
    always #5 clock = ~clock;
    cca_counter_array cca_counter_array_i (.clock(clock), .sys_rst(sys_rst), .reg_req(req),
        .reg_rdata_q(rdata), .timer0_overflow(t0), .external_count_input(ext),
        .cpu_idle(idle), .module_pin_in(pin_lvl), .module_pin_out(pout),
        .module_pin_oe(poe), .irq_q(irq), .watchdog_reset_q(wdr));
    cca_pins cca_pins_i (.clock(clock), .pin_out(pout), .pin_oe(poe), .drive(drv),
        .ext_en(ext_en), .pin_lvl(pin_lvl), .ext_cnt(ext));
    always @(posedge clock) begin
        if (wdr === 1'b1) wd_seen <= 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a, rv);
        chk($sformatf("reg %h", a), e, rv);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            t0 <= 1'b1;
            @(posedge clock);
            t0 <= 1'b0;
            cyc(2);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        cyc(10000);
        err_total++;
        give_verdict();
    end
    initial begin
        cyc(16);
        sys_rst <= 1'b0;
        @(posedge clock);
        rc(ADDR_CONTROL, 8'h00);
        rc(ADDR_MODE, 8'h00);
        rc(ADDR_COUNT_HI, 8'h00);
        rc(8'h40, 8'h00);
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_COUNT_LO, 8'hfe);
        wr(ADDR_COUNT_HI, 8'hff);
        wr(ADDR_CONTROL, 8'h40);
        tk(1);
        rc(ADDR_COUNT_LO, 8'hff);
        rc(ADDR_CONTROL, 8'h40);
        tk(1);
        rc(ADDR_COUNT_HI, 8'h00);
        rc(ADDR_CONTROL, 8'hc0);
        wr(ADDR_MODE, 8'h05);
        cyc(2);
        chk("irq", 16'h1, irq);
        wr(ADDR_CONTROL, 8'h00);
        tk(2);
        rc(ADDR_COUNT_LO, 8'h00);
        chk("irq", 16'h0, irq);
        wr(ADDR_MODE, 8'h84);
        idle <= 1'b1;
        wr(ADDR_CONTROL, 8'h40);
        tk(1);
        rc(ADDR_COUNT_LO, 8'h00);
        idle <= 1'b0;
        tk(1);
        rc(ADDR_COUNT_LO, 8'h01);
        wr(ADDR_MODE, 8'h06);
        ext_en <= 1'b1;
        cyc(80);
        ext_en <= 1'b0;
        cyc(8);
        rc(ADDR_COUNT_LO, 8'h15);
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_MODE, 8'(s * 2));
            wr(ADDR_COUNT_LO, 8'h00);
            wr(ADDR_CONTROL, 8'h40);
            cyc(60);
            wr(ADDR_CONTROL, 8'h00);
            rd(ADDR_COUNT_LO, rv);
            chk("rate", 16'h1, s == 0 ? rv inside {[8'h09:8'h0b]} : rv inside {[8'h1d:8'h20]});
        end
        wr(ADDR_COUNT_LO, 8'h34);
        wr(ADDR_COUNT_HI, 8'h12);
        wr(ADDR_MODMODE0 + 8'h01, 8'h21);
        wr(ADDR_MODMODE0 + 8'h02, 8'h10);
        drv <= 5'h02;
        cyc(4);
        rc(ADDR_VALUE0 + 8'h02, 8'h34);
        rc(ADDR_VALUE0 + 8'h03, 8'h12);
        rc(ADDR_VALUE0 + 8'h04, 8'h34);
        rc(ADDR_VALUE0 + 8'h05, 8'h12);
        rc(ADDR_CONTROL, 8'h06);
        chk("irq", 16'h1, irq);
        wr(ADDR_CONTROL, 8'h00);
        rc(ADDR_CONTROL, 8'h00);
        wr(ADDR_VALUE0, 8'h03);
        wr(ADDR_VALUE0 + 8'h01, 8'h00);
        wr(ADDR_MODMODE0, 8'h4d);
        wr(ADDR_COUNT_LO, 8'h00);
        wr(ADDR_COUNT_HI, 8'h00);
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_CONTROL, 8'h40);
        chk("oe0", 16'h1, poe[0]);
        tk(3);
        cyc(2);
        chk("pin0", 16'h1, pout[0]);
        rc(ADDR_CONTROL, 8'h41);
        wr(ADDR_MODMODE0, 8'h0d);
        wr(ADDR_COUNT_LO, 8'h02);
        tk(1);
        cyc(2);
        chk("pin0", 16'h1, pout[0]);
        wr(ADDR_VALUE0 + 8'h06, 8'h80);
        wr(ADDR_VALUE0 + 8'h07, 8'h80);
        wr(ADDR_MODMODE0 + 8'h03, 8'h42);
        wr(ADDR_COUNT_LO, 8'h7f);
        cyc(3);
        chk("pin3", 16'h0, pout[3]);
        tk(1);
        cyc(2);
        chk("pin3", 16'h1, pout[3]);
        wr(ADDR_VALUE0 + 8'h08, 8'h05);
        wr(ADDR_VALUE0 + 8'h09, 8'h00);
        wr(ADDR_MODMODE0 + 8'h04, 8'h40);
        wr(ADDR_COUNT_LO, 8'h04);
        tk(1);
        cyc(2);
        chk("wdog", 16'h0, wd_seen);
        wr(ADDR_MODE, 8'h44);
        wr(ADDR_COUNT_LO, 8'h04);
        tk(1);
        cyc(2);
        chk("wdog", 16'h1, wd_seen);
        give_verdict();
    end
endmodule

// file: logic/cca_channel.sv
`timescale 1ns/1ps
module cca_channel
    import cca_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire cca_mode_s   mode,
    input  wire logic [15:0] count,
    input  wire logic        count_upd,
    input  wire logic        low_wrap,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wdata,
    input  wire logic        pin_in,
    output logic [15:0]      value_q,
    output logic             pin_out_q,
    output logic             pin_oe_q,
    output logic             event_q,
    output logic             match_q
);
    logic pin_prev_q;
    logic rise;
    logic fall;
    logic capture;
    logic match;

    assign rise    = pin_in & ~pin_prev_q;
    assign fall    = ~pin_in & pin_prev_q;
    assign capture = (mode.capture_rising & rise) | (mode.capture_falling & fall);
    assign match   = mode.comparator_en & count_upd & (count == value_q);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            value_q <= {RESET_BYTE, RESET_BYTE};
        end else if (capture) begin
            value_q <= count;
        end else begin
            if (wr_low) begin
                value_q[7:0] <= wdata;
            end else if (mode.pwm_en & low_wrap) begin
                value_q[7:0] <= value_q[15:8];
            end
            if (wr_high) begin
                value_q[15:8] <= wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else if (mode.pwm_en) begin
            pin_oe_q  <= 1'b1;
            pin_out_q <= ~(count[7:0] < value_q[7:0]);
        end else if (mode.toggle_on_match) begin
            pin_oe_q <= 1'b1;
            if (match) begin
                pin_out_q <= ~pin_out_q;
            end
        end else begin
            pin_oe_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            event_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            event_q <= capture | (match & mode.flag_on_match);
            match_q <= match;
        end
    end
endmodule

// file: logic/cca_counter_array.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module cca_counter_array
    import cca_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire cca_bus_s               reg_req,
    output logic [7:0]                  reg_rdata_q,
    input  wire logic                   timer0_overflow,
    input  wire logic                   external_count_input,
    input  wire logic                   cpu_idle,
    input  wire logic [NUM_MODULES-1:0] module_pin_in,
    output logic [NUM_MODULES-1:0]      module_pin_out,
    output logic [NUM_MODULES-1:0]      module_pin_oe,
    output logic                        irq_q,
    output logic                        watchdog_reset_q
);
    logic [15:0]            count_q;
    logic [7:0]             mode_reg_q;
    logic                   overflow_flag_q;
    logic                   run_control_q;
    logic [NUM_MODULES-1:0] module_flags_q;
    logic [2:0]             prescale_q;
    logic                   ext_prev_q;
    logic                   count_upd_q;
    logic                   low_wrap_q;
    logic                   source_event;
    logic                   tick;
    logic                   overflow;
    logic                   ctl_wr;
    cca_src_e               source;

    cca_mode_s              module_mode_q [NUM_MODULES];
    logic [15:0]            value         [NUM_MODULES];
    logic [NUM_MODULES-1:0] event_pulse;
    logic [NUM_MODULES-1:0] match_pulse;
    logic [NUM_MODULES-1:0] wr_low;
    logic [NUM_MODULES-1:0] wr_high;
    logic [NUM_MODULES-1:0] irq_terms;

    assign source = cca_src_e'(mode_reg_q[MODE_SRC_HI:MODE_SRC_LO]);
    assign ctl_wr = reg_req.wr & (reg_req.addr == ADDR_CONTROL);

    always_comb begin
        case (source)
            CCA_SRC_DIV6: source_event = (prescale_q == DIV6_LAST);
            CCA_SRC_DIV2: source_event = (prescale_q >= DIV2_LAST) & prescale_q[0];
            CCA_SRC_TMR0: source_event = timer0_overflow;
            CCA_SRC_EXT:  source_event = external_count_input & ~ext_prev_q;
            default:      source_event = 1'b0;
        endcase
    end

    // Counting needs the run bit and is gated off in idle when asked.
    assign tick = run_control_q & source_event
                & ~(mode_reg_q[MODE_IDLE_BIT] & cpu_idle);
    assign overflow = tick & (count_q == COUNT_ALL_ONE);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prescale_q <= 3'h0;
        end else if ((source == CCA_SRC_DIV6 && prescale_q == DIV6_LAST)
                     || (source == CCA_SRC_DIV2 && prescale_q >= DIV2_LAST)) begin
            prescale_q <= 3'h0;
        end else begin
            prescale_q <= prescale_q + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= external_count_input;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_q <= {RESET_BYTE, RESET_BYTE};
        end else if (reg_req.wr && reg_req.addr == ADDR_COUNT_LO) begin
            count_q[7:0] <= reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == ADDR_COUNT_HI) begin
            count_q[15:8] <= reg_req.wdata;
        end else if (tick) begin
            count_q <= count_q + 16'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_upd_q <= 1'b0;
            low_wrap_q  <= 1'b0;
        end else begin
            count_upd_q <= tick;
            low_wrap_q  <= tick & (count_q[7:0] == LOW_ALL_ONE);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_reg_q <= RESET_BYTE;
        end else if (reg_req.wr && reg_req.addr == ADDR_MODE) begin
            mode_reg_q <= reg_req.wdata & MODE_RMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_control_q <= 1'b0;
        end else if (ctl_wr) begin
            run_control_q <= reg_req.wdata[CTL_RUN_BIT];
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overflow_flag_q <= 1'b0;
        end else if (ctl_wr) begin
            overflow_flag_q <= reg_req.wdata[CTL_OVF_BIT] | overflow;
        end else if (overflow) begin
            overflow_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            module_flags_q <= '0;
        end else if (ctl_wr) begin
            module_flags_q <= reg_req.wdata[NUM_MODULES-1:0] | event_pulse;
        end else begin
            module_flags_q <= module_flags_q | event_pulse;
        end
    end

    genvar n;
    generate
        for (n = 0; n < NUM_MODULES; n++) begin : g_mod
            localparam logic [7:0] MODE_ADDR = ADDR_MODMODE0 + 8'(n);
            localparam logic [7:0] LOW_ADDR  = ADDR_VALUE0 + 8'(2 * n);
            localparam logic [7:0] HIGH_ADDR = ADDR_VALUE0 + 8'(2 * n + 1);

            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    module_mode_q[n] <= cca_mode_s'(RESET_BYTE);
                end else if (reg_req.wr && reg_req.addr == MODE_ADDR) begin
                    module_mode_q[n] <= cca_mode_s'(reg_req.wdata & MODMODE_RMASK);
                end
            end

            assign wr_low[n]    = reg_req.wr & (reg_req.addr == LOW_ADDR);
            assign wr_high[n]   = reg_req.wr & (reg_req.addr == HIGH_ADDR);
            assign irq_terms[n] = module_flags_q[n] & module_mode_q[n].module_irq_en;

            cca_channel u_channel (
                .clock     (clock),
                .sys_rst   (sys_rst),
                .mode      (module_mode_q[n]),
                .count     (count_q),
                .count_upd (count_upd_q),
                .low_wrap  (low_wrap_q),
                .wr_low    (wr_low[n]),
                .wr_high   (wr_high[n]),
                .wdata     (reg_req.wdata),
                .pin_in    (module_pin_in[n]),
                .value_q   (value[n]),
                .pin_out_q (module_pin_out[n]),
                .pin_oe_q  (module_pin_oe[n]),
                .event_q   (event_pulse[n]),
                .match_q   (match_pulse[n])
            );
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (overflow_flag_q & mode_reg_q[MODE_OVFIE]) | (|irq_terms);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            watchdog_reset_q <= 1'b0;
        end else begin
            watchdog_reset_q <= mode_reg_q[MODE_WDOG_BIT]
                              & match_pulse[WATCHDOG_MOD];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_q <= RESET_BYTE;
        end else if (!reg_req.rd) begin
            reg_rdata_q <= RESET_BYTE;
        end else if (reg_req.addr == ADDR_CONTROL) begin
            reg_rdata_q <= {overflow_flag_q, run_control_q, 1'b0, module_flags_q} & CTL_RMASK;
        end else if (reg_req.addr == ADDR_MODE) begin
            reg_rdata_q <= mode_reg_q;
        end else if (reg_req.addr == ADDR_COUNT_LO) begin
            reg_rdata_q <= count_q[7:0];
        end else if (reg_req.addr == ADDR_COUNT_HI) begin
            reg_rdata_q <= count_q[15:8];
        end else if (reg_req.addr >= ADDR_MODMODE0
                     && reg_req.addr < ADDR_MODMODE0 + 8'(NUM_MODULES)) begin
            reg_rdata_q <= module_mode_q[3'(reg_req.addr - ADDR_MODMODE0)];
        end else if (reg_req.addr >= ADDR_VALUE0
                     && reg_req.addr < ADDR_VALUE0 + 8'(2 * NUM_MODULES)) begin
            reg_rdata_q <= reg_req.addr[0]
                ? value[3'((reg_req.addr - ADDR_VALUE0) >> 1)][15:8]
                : value[3'((reg_req.addr - ADDR_VALUE0) >> 1)][7:0];
        end else begin
            reg_rdata_q <= RESET_BYTE;
        end
    end
endmodule

// file: logic/cca_pkg.sv
package cca_pkg;

    localparam int unsigned NUM_MODULES  = 5;
    localparam int unsigned WATCHDOG_MOD = 4;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_MODE      = 8'h01;
    localparam logic [7:0] ADDR_COUNT_LO  = 8'h02;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'h03;
    localparam logic [7:0] ADDR_MODMODE0  = 8'h04;
    localparam logic [7:0] ADDR_VALUE0    = 8'h10;

    // Counter control register fields.
    localparam int unsigned CTL_OVF_BIT   = 7;
    localparam int unsigned CTL_RUN_BIT   = 6;
    localparam logic [7:0]  CTL_RMASK     = 8'hdf;

    // Counter mode register fields.
    localparam int unsigned MODE_IDLE_BIT = 7;
    localparam int unsigned MODE_WDOG_BIT = 6;
    localparam int unsigned MODE_SRC_HI   = 2;
    localparam int unsigned MODE_SRC_LO   = 1;
    localparam int unsigned MODE_OVFIE    = 0;
    localparam logic [7:0]  MODE_RMASK    = 8'hc7;

    localparam logic [7:0]  MODMODE_RMASK = 8'h7f;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam logic [15:0] COUNT_ALL_ONE = 16'hffff;
    localparam logic [7:0]  LOW_ALL_ONE   = 8'hff;

    // Count source codes and fixed prescale divisors.
    localparam logic [1:0] SRC_DIV6  = 2'h0;
    localparam logic [1:0] SRC_DIV2  = 2'h1;
    localparam logic [1:0] SRC_TMR0  = 2'h2;
    localparam logic [1:0] SRC_EXT   = 2'h3;
    localparam logic [2:0] DIV6_LAST = 3'h5;
    localparam logic [2:0] DIV2_LAST = 3'h1;

    typedef enum logic [1:0] {
        CCA_SRC_DIV6 = 2'b00,
        CCA_SRC_DIV2 = 2'b01,
        CCA_SRC_TMR0 = 2'b10,
        CCA_SRC_EXT  = 2'b11
    } cca_src_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cca_bus_s;

    typedef struct packed {
        logic reserved;
        logic comparator_en;
        logic capture_rising;
        logic capture_falling;
        logic flag_on_match;
        logic toggle_on_match;
        logic pwm_en;
        logic module_irq_en;
    } cca_mode_s;

endpackage
